/* dpt_pkg.sv */
// Package for the dual-output preset timer: constants, codes and carriers.
// Assumes a single 25 MHz clock and synchronous field and key inputs.
package dpt_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int FILT_FAST_MS = 1;
    localparam int FILT_SLOW_MS = 20;
    localparam int FILT_FAST_CYC = FILT_FAST_MS * CYC_PER_MS;
    localparam int FILT_SLOW_CYC = FILT_SLOW_MS * CYC_PER_MS;
    localparam int PV_W = 20;
    localparam int MS_W = 20;
    localparam int FILT_W = 20;
    // Length of one count step in ms, per range
    localparam logic [MS_W-1:0] UNIT_CS_MS = 20'h0000a;
    localparam logic [MS_W-1:0] UNIT_S_MS = 20'h003e8;
    localparam logic [MS_W-1:0] UNIT_TM_MS = 20'h01770;
    localparam logic [MS_W-1:0] UNIT_TH_MS = 20'h57e40;
    localparam logic [MS_W-1:0] BLINK_MS = 20'h001f4;
    // Display maxima: 999999 counts, or 99 h 59 min 59 s in seconds
    localparam logic [PV_W-1:0] PV_MAX_DEC = 20'hf423f;
    localparam logic [PV_W-1:0] PV_MAX_HMS = 20'h57e3f;
    localparam logic [7:0] DIP_RST_VAL = 8'h00;
    // Bit positions of the DIP switch word, pin 1 at bit 0
    localparam int DIP_RANGE_LO = 0;
    localparam int DIP_RANGE_HI = 1;
    localparam int DIP_MODE = 2;
    localparam int DIP_WIDTH = 3;
    localparam int DIP_INPUT = 4;
    localparam int DIP_PROT_RST = 5;
    localparam int DIP_PROT_UP = 6;
    localparam int DIP_PROT_MODE = 7;
    localparam int N_FIELD = 3;

    // Range code is {pin2, pin1}
    typedef enum logic [1:0] {
        DPT_R_TENTH_H = 2'h0,
        DPT_R_CENTI_S = 2'h1,
        DPT_R_HMS = 2'h2,
        DPT_R_TENTH_M = 2'h3
    } dpt_range_t;

    typedef enum logic {
        DPT_ST_FORECAST = 1'b0,
        DPT_ST_ABSOLUTE = 1'b1
    } dpt_style_t;

    typedef struct packed {
        logic prot_mode;
        logic prot_up;
        logic prot_reset;
        logic pnp_input;
        logic fast_input;
        logic delay_mode;
        dpt_range_t range;
    } dpt_cfg_t;

    typedef struct packed {
        logic gate;
        logic rst;
        logic start;
    } dpt_field_t;

    typedef struct packed {
        logic first;
        logic second;
    } dpt_outs_t;
endpackage

/* dpt_tick_div.sv */
// One-cycle enable pulse every DIV clocks.
// Assumes the single system clock and active-low asynchronous reset.
`timescale 1ns/10ps
module dpt_tick_div #(
    parameter int DIV = dpt_pkg::CYC_PER_MS,
    parameter int CW = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Enable pulse
    output logic tick
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    always_comb begin
        cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = (cnt_r == LAST);
endmodule

/* dpt_filter.sv */
// Width filter for the field inputs: an output follows its input only after
// the input has held a new level for lim consecutive clocks.
// Assumes inputs already synchronous to clk.
`timescale 1ns/10ps
module dpt_filter #(
    parameter int N = dpt_pkg::N_FIELD,
    parameter int CW = dpt_pkg::FILT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Raw levels and required width in clocks
    input wire logic [N-1:0] raw,
    input wire logic [CW-1:0] lim,
    // Filtered levels
    output logic [N-1:0] filt
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            logic [CW-1:0] cnt_r;
            logic [CW-1:0] cnt_nxt;
            logic lvl_r;
            logic lvl_nxt;
            always_comb begin
                cnt_nxt = '0;
                lvl_nxt = lvl_r;
                if (raw[i] != lvl_r) begin
                    if (cnt_r >= lim - 1'b1) begin
                        lvl_nxt = raw[i];
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_r <= '0;
                    lvl_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_nxt;
                    lvl_r <= lvl_nxt;
                end
            end
            assign filt[i] = lvl_r;
        end
    endgenerate
endmodule

/* dpt_timer.sv */
// Control core of the dual-output preset timer: switch capture, key
// protection, run and function setting modes, timing and output compare.
// Assumes synchronous inputs, keys as levels or one-cycle pulses.
`timescale 1ns/10ps
module dpt_timer #(
    parameter int CYC_MS = dpt_pkg::CYC_PER_MS,
    parameter int FAST_CYC = dpt_pkg::FILT_FAST_CYC,
    parameter int SLOW_CYC = dpt_pkg::FILT_SLOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Switches
    input wire logic [7:0] dip_sw,
    input wire logic kp_sw,
    // Field inputs
    input wire dpt_pkg::dpt_field_t field_in,
    // Operator keys
    input wire logic reset_key,
    input wire logic up_key,
    input wire logic up_sel,
    input wire logic [dpt_pkg::PV_W-1:0] up_data,
    input wire logic mode_key,
    input wire logic fn_wr,
    input wire dpt_pkg::dpt_style_t fn_style,
    // Outputs and indicators
    output logic first_output,
    output logic second_output,
    output logic first_output_led,
    output logic second_output_led,
    output logic reset_led,
    output logic kp_led,
    output logic dp_on,
    output logic fn_mode,
    output logic timing,
    output logic [dpt_pkg::PV_W-1:0] present_value
);
    typedef enum logic [1:0] {DLY_IDLE, DLY_RUN, DLY_DONE} dpt_dly_t;

    // Configuration captured once after power-up
    dpt_pkg::dpt_cfg_t cfg_r, cfg_nxt;
    logic cfg_taken_r, cfg_taken_nxt;

    always_comb begin
        cfg_nxt = cfg_r;
        cfg_taken_nxt = 1'b1;
        if (!cfg_taken_r) begin
            cfg_nxt = dpt_pkg::dpt_cfg_t'(dip_sw);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= dpt_pkg::dpt_cfg_t'(dpt_pkg::DIP_RST_VAL);
            cfg_taken_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cfg_taken_r <= cfg_taken_nxt;
        end
    end

    // Input filter width from switch 4
    logic [dpt_pkg::FILT_W-1:0] filt_lim;
    dpt_pkg::dpt_field_t fld;
    logic [dpt_pkg::N_FIELD-1:0] fld_bits;
    assign filt_lim = cfg_r.fast_input ? dpt_pkg::FILT_W'(FAST_CYC)
                                       : dpt_pkg::FILT_W'(SLOW_CYC);
    assign fld = dpt_pkg::dpt_field_t'(fld_bits);

    dpt_filter #(.N(dpt_pkg::N_FIELD), .CW(dpt_pkg::FILT_W)) u_filt (
        .clk(clk),
        .rstn(rstn),
        .raw(field_in),
        .lim(filt_lim),
        .filt(fld_bits)
    );

    logic ms_tick;
    dpt_tick_div #(.DIV(CYC_MS), .CW(dpt_pkg::MS_W)) u_ms (
        .clk(clk),
        .rstn(rstn),
        .tick(ms_tick)
    );

    // Key protection, live from the switch
    logic rkey_ok, up_ok, mode_ok, rst_act;
    assign rkey_ok = reset_key & ~(kp_sw & cfg_r.prot_reset);
    assign up_ok = up_key & ~(kp_sw & cfg_r.prot_up);
    assign mode_ok = mode_key & ~(kp_sw & cfg_r.prot_mode);
    assign rst_act = fld.rst | rkey_ok;
    assign reset_led = fld.rst | rkey_ok;
    assign kp_led = kp_sw;

    // Mode handling, set values and pending function parameters
    logic fn_r, fn_nxt;
    dpt_pkg::dpt_style_t style_r, style_nxt, pend_r, pend_nxt;
    logic [dpt_pkg::PV_W-1:0] sv1_r, sv1_nxt, sv2_r, sv2_nxt;

    always_comb begin
        fn_nxt = fn_r;
        style_nxt = style_r;
        pend_nxt = pend_r;
        sv1_nxt = sv1_r;
        sv2_nxt = sv2_r;
        if (fn_r) begin
            if (fn_wr) begin
                pend_nxt = fn_style;
            end
            if (mode_ok) begin
                fn_nxt = 1'b0;
                style_nxt = fn_wr ? fn_style : pend_r;
            end
        end else begin
            if (mode_ok && !kp_sw) begin
                fn_nxt = 1'b1;
                pend_nxt = style_r;
            end
            if (up_ok && !up_sel) begin
                sv1_nxt = up_data;
            end
            if (up_ok && up_sel) begin
                sv2_nxt = up_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fn_r <= 1'b0;
            style_r <= dpt_pkg::DPT_ST_FORECAST;
            pend_r <= dpt_pkg::DPT_ST_FORECAST;
            sv1_r <= '0;
            sv2_r <= '0;
        end else begin
            fn_r <= fn_nxt;
            style_r <= style_nxt;
            pend_r <= pend_nxt;
            sv1_r <= sv1_nxt;
            sv2_r <= sv2_nxt;
        end
    end
    assign fn_mode = fn_r;

    // Timing: unit step from range, start and stop per output mode
    logic [dpt_pkg::MS_W-1:0] unit_ms, pv_max_w;
    logic [dpt_pkg::PV_W-1:0] pv_max;
    always_comb begin
        unit_ms = dpt_pkg::UNIT_TH_MS;
        pv_max = dpt_pkg::PV_MAX_DEC;
        case (cfg_r.range)
            dpt_pkg::DPT_R_CENTI_S: unit_ms = dpt_pkg::UNIT_CS_MS;
            dpt_pkg::DPT_R_HMS: begin
                unit_ms = dpt_pkg::UNIT_S_MS;
                pv_max = dpt_pkg::PV_MAX_HMS;
            end
            dpt_pkg::DPT_R_TENTH_M: unit_ms = dpt_pkg::UNIT_TM_MS;
            default: unit_ms = dpt_pkg::UNIT_TH_MS;
        endcase
    end
    assign pv_max_w = pv_max;

    dpt_dly_t dly_r, dly_nxt;
    logic [dpt_pkg::PV_W-1:0] pv_r, pv_nxt;
    logic [dpt_pkg::MS_W-1:0] ms_r, ms_nxt;
    logic start_q_r, rst_q_r, started_r, started_nxt, run;
    logic start_req, time_up;
    dpt_pkg::dpt_outs_t out_r, out_nxt, hit;

    assign start_req = fld.start & (~start_q_r | rst_q_r);
    assign time_up = pv_r >= sv2_r;

    always_comb begin
        dly_nxt = dly_r;
        started_nxt = started_r;
        run = 1'b0;
        if (rst_act) begin
            dly_nxt = DLY_IDLE;
            started_nxt = 1'b0;
        end else if (cfg_r.delay_mode) begin
            case (dly_r)
                DLY_IDLE: begin
                    if (start_req) begin
                        dly_nxt = DLY_RUN;
                        started_nxt = 1'b1;
                    end
                end
                DLY_RUN: begin
                    run = ~fld.gate;
                    if (time_up) begin
                        dly_nxt = DLY_DONE;
                    end
                end
                default: dly_nxt = DLY_DONE;
            endcase
        end else begin
            run = fld.start & ~fld.gate;
            if (fld.start) begin
                started_nxt = 1'b1;
            end
        end
    end

    always_comb begin
        pv_nxt = pv_r;
        ms_nxt = ms_r;
        if (rst_act) begin
            pv_nxt = '0;
            ms_nxt = '0;
        end else if (run && ms_tick) begin
            if (ms_r >= unit_ms - 1'b1) begin
                ms_nxt = '0;
                if (pv_r < pv_max_w) begin
                    pv_nxt = pv_r + 1'b1;
                end
            end else begin
                ms_nxt = ms_r + 1'b1;
            end
        end
    end

    // Compare against set values; outputs are sustained until reset
    always_comb begin
        if (style_r == dpt_pkg::DPT_ST_FORECAST) begin
            hit.first = (sv1_r >= sv2_r) | (pv_r >= sv2_r - sv1_r);
            hit.second = time_up;
        end else begin
            hit.first = pv_r >= sv1_r;
            hit.second = time_up;
        end
        out_nxt = rst_act ? '0 : (out_r | (hit & {2{started_nxt}}));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dly_r <= DLY_IDLE;
            started_r <= 1'b0;
            pv_r <= '0;
            ms_r <= '0;
            out_r <= '0;
            start_q_r <= 1'b0;
            rst_q_r <= 1'b1;
        end else begin
            dly_r <= dly_nxt;
            started_r <= started_nxt;
            pv_r <= pv_nxt;
            ms_r <= ms_nxt;
            out_r <= out_nxt;
            start_q_r <= fld.start;
            rst_q_r <= rst_act;
        end
    end

    // Decimal point blink for the tenth ranges
    logic [dpt_pkg::MS_W-1:0] blk_r, blk_nxt;
    logic blink_r, blink_nxt, tenth;
    always_comb begin
        blk_nxt = blk_r;
        blink_nxt = blink_r;
        if (ms_tick) begin
            if (blk_r >= dpt_pkg::BLINK_MS - 1'b1) begin
                blk_nxt = '0;
                blink_nxt = ~blink_r;
            end else begin
                blk_nxt = blk_r + 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blk_r <= '0;
            blink_r <= 1'b0;
        end else begin
            blk_r <= blk_nxt;
            blink_r <= blink_nxt;
        end
    end
    assign tenth = (cfg_r.range == dpt_pkg::DPT_R_TENTH_H) |
                   (cfg_r.range == dpt_pkg::DPT_R_TENTH_M);
    assign dp_on = tenth & (run ? blink_r : 1'b1);
    assign timing = run;

    assign first_output = out_r.first;
    assign second_output = out_r.second;
    assign first_output_led = out_r.first;
    assign second_output_led = out_r.second;
    assign present_value = pv_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_reset_seen;
        rst_act;
    endsequence
    sequence s_outputs_cleared;
        pv_r == '0 && out_r == '0;
    endsequence
    sequence s_delay_done;
        cfg_r.delay_mode && dly_r == DLY_DONE && !rst_act;
    endsequence

    property p_reset_clear;
        s_reset_seen |=> s_outputs_cleared;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset did not clear value and outputs");

    property p_reset_led;
        reset_led == (fld.rst || (reset_key && !(kp_sw && cfg_r.prot_reset)));
    endproperty
    a_reset_led: assert property (p_reset_led)
        else $error("reset indicator wrong");

    property p_led_follow;
        first_output_led == first_output && second_output_led == second_output;
    endproperty
    a_led_follow: assert property (p_led_follow)
        else $error("output indicator does not follow output");

    property p_no_fn_entry;
        !fn_r && kp_sw |=> !fn_r;
    endproperty
    a_no_fn_entry: assert property (p_no_fn_entry)
        else $error("function mode entered under key protect");

    property p_cfg_frozen;
        cfg_taken_r |=> $stable(cfg_r);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("configuration changed after power-up");

    property p_pending;
        fn_r && fn_nxt |=> $stable(style_r);
    endproperty
    a_pending: assert property (p_pending)
        else $error("style changed inside function mode");

    property p_fc_second;
        started_r && pv_r >= sv2_r && !rst_act ##1 !rst_act |-> second_output;
    endproperty
    a_fc_second: assert property (p_fc_second)
        else $error("second output missing at set value");

    property p_abs_first;
        style_r == dpt_pkg::DPT_ST_ABSOLUTE && started_r && pv_r >= sv1_r &&
            !rst_act ##1 !rst_act |-> first_output;
    endproperty
    a_abs_first: assert property (p_abs_first)
        else $error("first output missing at set value 1");

    property p_delay_stop;
        s_delay_done ##1 !rst_act |-> $stable(pv_r) && second_output;
    endproperty
    a_delay_stop: assert property (p_delay_stop)
        else $error("delay mode kept counting after time up");

    property p_kp_led;
        kp_led == kp_sw;
    endproperty
    a_kp_led: assert property (p_kp_led)
        else $error("key protection indicator wrong");
endmodule

/* dpt_field_model.sv */
// Field side model: start, reset and gate sensors with contact chatter.
// Assumes the bench sets the wanted levels; a change chatters two clocks.
`timescale 1ns/10ps
module dpt_field_model (
    // Clock
    input wire logic clk,
    // Wanted and driven levels
    input wire dpt_pkg::dpt_field_t want,
    output dpt_pkg::dpt_field_t field_in
);
    dpt_pkg::dpt_field_t held;
    dpt_pkg::dpt_field_t diff;
    int bounce;

    initial begin
        held = '0;
        diff = '0;
        field_in = '0;
        bounce = 0;
    end

    // Changed lines bounce once before they settle
    always @(negedge clk) begin
        if (want != held) begin
            diff <= want ^ held;
            held <= want;
            field_in <= want;
            bounce <= 2;
        end else if (bounce == 2) begin
            field_in <= held ^ diff;
            bounce <= 1;
        end else begin
            field_in <= held;
            bounce <= 0;
        end
    end
endmodule

/* tb.sv */
// Self-checking bench for the dual-output preset timer core.
// Assumes shortened ms tick and filter counts for a short run.
`timescale 1ns/10ps
module tb;
    localparam int CYC = 4;
    localparam int SLOW = 10;
    localparam int STEP = 10 * CYC;
    logic clk, rstn, kp_sw, reset_key, up_key, up_sel, mode_key, fn_wr;
    logic [7:0] dip_sw;
    logic [dpt_pkg::PV_W-1:0] up_data, present_value, pv0;
    dpt_pkg::dpt_style_t fn_style;
    dpt_pkg::dpt_field_t want, field_in;
    logic first_output, second_output, first_output_led, second_output_led;
    logic reset_led, kp_led, dp_on, fn_mode, timing;
    int errors, compares, seed, sv1, sv2, last, n;
    int cyc = 0;

    dpt_field_model fm_u (.clk(clk), .want(want), .field_in(field_in));

    dpt_timer #(.CYC_MS(CYC), .FAST_CYC(3), .SLOW_CYC(SLOW)) dut_u (
        .clk(clk), .rstn(rstn), .dip_sw(dip_sw), .kp_sw(kp_sw),
        .field_in(field_in), .reset_key(reset_key), .up_key(up_key),
        .up_sel(up_sel), .up_data(up_data), .mode_key(mode_key),
        .fn_wr(fn_wr), .fn_style(fn_style), .first_output(first_output),
        .second_output(second_output), .first_output_led(first_output_led),
        .second_output_led(second_output_led), .reset_led(reset_led), .kp_led(kp_led),
        .dp_on(dp_on), .fn_mode(fn_mode), .timing(timing),
        .present_value(present_value)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            end_sim();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic do_reset(input logic [7:0] d);
        rstn = 1'b0;
        dip_sw = d;
        tick(16);
        rstn = 1'b1;
        tick(2);
    endtask

    // 0 mode key, 1 up key, 2 function write
    task automatic press(input int k);
        mode_key = (k == 0);
        up_key = (k == 1);
        fn_wr = (k == 2);
        tick(1);
        mode_key = 1'b0;
        up_key = 1'b0;
        fn_wr = 1'b0;
        tick(1);
    endtask

    task automatic load(input logic sel, input int v);
        up_sel = sel;
        up_data = v[dpt_pkg::PV_W-1:0];
        press(1);
    endtask

    task automatic wait_pv(input int k);
        for (int i = 0; i < 4 * STEP && present_value < k; i++)
            tick(1);
    endtask

    // Expected {first, second} for a count of pv
    function automatic logic [1:0] model(input int pv, input int a,
                                         input int b, input bit abs_s);
        if (abs_s)
            return {pv >= a, pv >= b};
        return {(a >= b) || (pv >= b - a), pv >= b};
    endfunction

    task automatic run(input int top, input bit abs_s, input bit fn1);
        for (int k = 1; k <= top; k++) begin
            wait_pv(k);
            if (k > 1)
                check("step", cyc - last, STEP);
            last = cyc;
            tick(2);
            check("outs", {first_output, second_output},
                  model(k, sv1, sv2, abs_s));
            check("leds", {first_output_led, second_output_led},
                  {first_output, second_output});
            check("timing", timing, 1'b1);
            if (fn1 && k == 1) begin
                press(0);
                fn_style = dpt_pkg::DPT_ST_ABSOLUTE;
                press(2);
                check("fn_mode", fn_mode, 1'b1);
            end
        end
    endtask

    initial begin
        rstn = 1'b0;
        seed = 32'he744;
        {kp_sw, reset_key, up_key, up_sel, mode_key, fn_wr} = '0;
        up_data = '0;
        dip_sw = 8'h00;
        want = '0;
        fn_style = dpt_pkg::DPT_ST_FORECAST;
        errors = 0;
        compares = 0;
        // Factory defaults
        do_reset(8'h00);
        check("dp_on", dp_on, 1'b1);
        kp_sw = 1'b1;
        reset_key = 1'b1;
        tick(1);
        check("kp_led", kp_led, 1'b1);
        check("reset_led", reset_led, 1'b1);
        press(0);
        check("fn_mode", fn_mode, 1'b0);
        reset_key = 1'b0;
        kp_sw = 1'b0;
        tick(1);
        check("kp_led", kp_led, 1'b0);
        $display("defaults test done");
        // Forecast counting, style change pending in function mode
        do_reset(8'h01);
        check("dp_on", dp_on, 1'b0);
        sv1 = 1 + ($random(seed) & 3);
        sv2 = sv1 + 2 + ($random(seed) & 3);
        load(1'b0, sv1);
        load(1'b1, sv2);
        want.start <= 1'b1;
        run(sv2 + 1, 1'b0, 1'b1);
        want.start <= 1'b0;
        tick(SLOW + 6);
        pv0 = present_value;
        tick(3 * STEP);
        check("pv_pause", present_value, pv0);
        check("timing", timing, 1'b0);
        // Gate held with start keeps the count frozen
        want.start <= 1'b1;
        want.gate <= 1'b1;
        tick(SLOW + 6 + 3 * STEP);
        check("pv_gate", present_value, pv0);
        check("timing", timing, 1'b0);
        want.start <= 1'b0;
        want.gate <= 1'b0;
        tick(SLOW + 6);
        want.rst <= 1'b1;
        tick(4);
        want.rst <= 1'b0;
        tick(SLOW + 4);
        check("pv_glitch", present_value, pv0);
        press(0);
        check("fn_mode", fn_mode, 1'b0);
        want.rst <= 1'b1;
        tick(SLOW + 6);
        check("pv_rst", present_value, 0);
        check("outs_rst", {first_output, second_output}, 2'h0);
        check("reset_led", reset_led, 1'b1);
        want.rst <= 1'b0;
        tick(SLOW + 4);
        n = sv1;
        sv1 = sv2 + 1;
        sv2 = n;
        load(1'b0, sv1);
        load(1'b1, sv2);
        want.start <= 1'b1;
        run(sv1 + 1, 1'b1, 1'b0);
        $display("counting test done");
        // Key protection
        want.start <= 1'b0;
        dip_sw = 8'he1;
        kp_sw = 1'b1;
        reset_key = 1'b1;
        tick(1);
        check("reset_led", reset_led, 1'b1);
        reset_key = 1'b0;
        kp_sw = 1'b0;
        do_reset(8'he1);
        kp_sw = 1'b1;
        reset_key = 1'b1;
        tick(1);
        check("reset_led", reset_led, 1'b0);
        load(1'b1, 1);
        press(0);
        check("fn_mode", fn_mode, 1'b0);
        kp_sw = 1'b0;
        tick(1);
        check("reset_led", reset_led, 1'b1);
        reset_key = 1'b0;
        want.start <= 1'b1;
        tick(SLOW + 6);
        check("second", second_output, 1'b1);
        press(0);
        check("fn_mode", fn_mode, 1'b1);
        press(0);
        $display("protection test done");
        // Signal-on delay with deviation above set value
        want.start <= 1'b0;
        do_reset(8'h05);
        sv1 = 5;
        sv2 = 3;
        load(1'b0, sv1);
        load(1'b1, sv2);
        want.start <= 1'b1;
        tick(SLOW + 6);
        check("first", first_output, 1'b1);
        wait_pv(sv2);
        tick(3 * STEP);
        check("pv_stop", present_value, sv2);
        check("second", second_output, 1'b1);
        check("timing", timing, 1'b0);
        want.start <= 1'b0;
        tick(SLOW + 6);
        want.start <= 1'b1;
        tick(SLOW + 6);
        check("pv_stop", present_value, sv2);
        reset_key = 1'b1;
        tick(2);
        check("pv_key", present_value, 0);
        check("outs_key", {first_output, second_output}, 2'h0);
        reset_key = 1'b0;
        $display("delay test done");
        // Decimal point flashes while timing in tenth-minute range
        do_reset(8'h03);
        n = 0;
        for (int i = 0; i < 1100 * CYC; i++) begin
            pv0[0] = dp_on;
            tick(1);
            n = n + (pv0[0] !== dp_on);
        end
        check("dp_flash", n >= 2, 1'b1);
        $display("flash test done");
        end_sim();
    end
endmodule
